// *** bix_consts.vh ***
// Constants for the branch, increment, OR and shift execution block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef BIX_CONSTS_VH
`define BIX_CONSTS_VH

// Operation select codes on the issue port.
`define BIX_OP_W                3
`define BIX_OP_JUMP_ABSOLUTE    3'h0
`define BIX_OP_INCREMENT_SKIP   3'h1
`define BIX_OP_INCREMENT_FILE   3'h2
`define BIX_OP_OR_LITERAL       3'h3
`define BIX_OP_OR_FILE          3'h4
`define BIX_OP_SHIFT_LEFT_FILE  3'h5

// Operand widths.
`define BIX_JUMP_K_W            11
`define BIX_FILE_AW             7
`define BIX_DATA_W              8
`define BIX_PC_W                15
`define BIX_LATCH_W             7
`define BIX_LATCH_HI            6
`define BIX_LATCH_LO            3

// APB register byte offsets.
`define BIX_ADDR_W              12
`define BIX_OFS_ACC             12'h000
`define BIX_OFS_STATUS          12'h004
`define BIX_OFS_LATCH           12'h008
`define BIX_OFS_PC              12'h00C
`define BIX_FILE_WIN_TAG        3'h1
`define BIX_FILE_WIN_HI         11
`define BIX_FILE_WIN_LO         9

// Status register fields.
`define BIX_ST_CARRY            0
`define BIX_ST_ZERO             1

// Reset values.
`define BIX_RST_ACC             8'h00
`define BIX_RST_LATCH           7'h00
`define BIX_RST_PC              15'h0000

`endif

// *** bix_file_mem.v ***
// Single-port file register memory with registered read data.
// Assumes one user per cycle; the caller arbitrates the port.
`timescale 1ns/1ps
module bix_file_mem #(
	parameter AW = 7,
	parameter DW = 8
) (
	input  wire          pclk,
	input  wire          we,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg  [DW-1:0] rdata_ff
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Read data is the word before any write of the same cycle.
	always @(posedge pclk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata_ff <= mem[addr];
	end
endmodule

// *** bix_exec.v ***
// Execution unit for absolute jump, increments, inclusive OR and left shift.
// Assumes synchronous issue inputs on pclk and an APB master for the registers.
//
// Notes on behaviour
// - An absolute jump loads its eleven-bit operand into program counter bits 10 to 0.
// - An absolute jump fills program counter bits 14 to 11 from upper target latch bits 6 to 3.
// - An absolute jump takes two cycles and leaves carry and zero untouched.
// - Increment with skip writes the file value plus one to the accumulator or the file and keeps the flags.
// - A zero result of increment with skip inserts one no-operation cycle and skips the next instruction.
// - OR literal ORs the accumulator with an 8-bit immediate into the accumulator and updates zero.
// - OR with file ORs accumulator and file into the selected target and updates zero.
// - Left shift moves operand bit 7 into carry and bits 6 to 0 into result bits 7 to 1, updating carry and zero.
// - Left shift forces result bit 0 to zero instead of the old carry.
// - Left shift writes to the accumulator when the target select is 0 and to the file when it is 1.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "bix_consts.vh"
module bix_exec #(
	parameter FILE_AW = `BIX_FILE_AW
) (
	input  wire                     pclk,
	input  wire                     presetn,
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [`BIX_ADDR_W-1:0]   paddr,
	input  wire [31:0]              pwdata,
	output reg  [31:0]              prdata_ff,
	output reg                      pready_ff,
	output reg                      pslverr_ff,
	input  wire                     issue_valid,
	input  wire [`BIX_OP_W-1:0]     issue_op,
	input  wire [`BIX_JUMP_K_W-1:0] issue_k,
	input  wire [FILE_AW-1:0]       issue_f,
	input  wire                     issue_d,
	output reg                      issue_ready_ff,
	output reg  [`BIX_PC_W-1:0]     program_counter_ff,
	output reg  [`BIX_DATA_W-1:0]   acc_ff,
	output reg                      carry_ff,
	output reg                      zero_ff
);
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_JUMP2 = 3'h1;
	localparam [2:0] S_READ  = 3'h2;
	localparam [2:0] S_EXEC  = 3'h3;
	localparam [2:0] S_NOP   = 3'h4;

	reg  [2:0]                state_ff;
	reg  [2:0]                nxt_state;
	reg  [`BIX_OP_W-1:0]      op_ff;
	reg  [`BIX_JUMP_K_W-1:0]  k_ff;
	reg  [FILE_AW-1:0]        f_ff;
	reg                       d_ff;
	reg  [`BIX_LATCH_W-1:0]   latch_ff;
	reg                       apb_rd_pend_ff;
	reg  [`BIX_DATA_W-1:0]    result;
	reg                       res_carry;
	wire [`BIX_DATA_W-1:0]    mem_rdata;
	wire                      accept;
	wire                      grant;
	wire                      apb_req;
	wire                      apb_file;
	wire [FILE_AW-1:0]        apb_index;
	wire                      core_mem_we;
	wire                      apb_mem_we;
	wire                      mem_we;
	wire [FILE_AW-1:0]        mem_addr;
	wire [`BIX_DATA_W-1:0]    mem_wdata;
	wire                      res_zero;

	// Operations that fetch their operand from the file memory.
	function uses_file;
		input [`BIX_OP_W-1:0] op;
		begin
			uses_file = (op == `BIX_OP_INCREMENT_SKIP) || (op == `BIX_OP_INCREMENT_FILE) ||
				(op == `BIX_OP_OR_FILE) || (op == `BIX_OP_SHIFT_LEFT_FILE);
		end
	endfunction

	// Registers of the APB map outside the file memory window.
	function reg_hit;
		input [`BIX_ADDR_W-1:0] a;
		begin
			reg_hit = (a == `BIX_OFS_ACC) || (a == `BIX_OFS_STATUS) ||
				(a == `BIX_OFS_LATCH) || (a == `BIX_OFS_PC);
		end
	endfunction

	assign accept = issue_valid && issue_ready_ff;
	// Software waits while the core works, so core and bus never update the same state together.
	// A master that keeps issue_valid high without a break starves the bus.
	assign grant     = (state_ff == S_IDLE) && !issue_valid;
	assign apb_req   = psel && penable && !pready_ff && grant;
	assign apb_file  = (paddr[`BIX_FILE_WIN_HI:`BIX_FILE_WIN_LO] == `BIX_FILE_WIN_TAG);
	assign apb_index = paddr[FILE_AW+1:2];

	always @*
	begin
		result    = mem_rdata;
		res_carry = carry_ff;
		case (op_ff)
			`BIX_OP_INCREMENT_SKIP,
			`BIX_OP_INCREMENT_FILE:
				result = mem_rdata + 8'h01;
			`BIX_OP_OR_FILE:
				result = acc_ff | mem_rdata;
			`BIX_OP_SHIFT_LEFT_FILE:
			begin
				result    = {mem_rdata[6:0], 1'b0};
				res_carry = mem_rdata[7];
			end
			default:
				result = mem_rdata;
		endcase
	end

	assign res_zero    = (result == 8'h00);
	assign core_mem_we = (state_ff == S_EXEC) && d_ff;
	assign apb_mem_we  = apb_req && pwrite && apb_file;
	assign mem_we      = core_mem_we || apb_mem_we;
	assign mem_addr    = (state_ff == S_IDLE) ? (issue_valid ? issue_f : apb_index) : f_ff;
	assign mem_wdata   = core_mem_we ? result : pwdata[`BIX_DATA_W-1:0];

	bix_file_mem #(
		.AW (FILE_AW),
		.DW (`BIX_DATA_W)
	) u_file_mem (
		.pclk     (pclk),
		.we       (mem_we),
		.addr     (mem_addr),
		.wdata    (mem_wdata),
		.rdata_ff (mem_rdata)
	);

	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:
				if (accept && issue_op == `BIX_OP_JUMP_ABSOLUTE)
					nxt_state = S_JUMP2;
				else if (accept && uses_file(issue_op))
					nxt_state = S_READ;
			S_JUMP2:
				nxt_state = S_IDLE;
			S_READ:
				nxt_state = S_EXEC;
			S_EXEC:
				if (op_ff == `BIX_OP_INCREMENT_SKIP && res_zero)
					nxt_state = S_NOP;
				else
					nxt_state = S_IDLE;
			S_NOP:
				nxt_state = S_IDLE;
			default:
				nxt_state = S_IDLE;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff           <= S_IDLE;
			issue_ready_ff     <= 1'b1;
			op_ff              <= `BIX_OP_JUMP_ABSOLUTE;
			k_ff               <= 11'h000;
			f_ff               <= {FILE_AW{1'b0}};
			d_ff               <= 1'b0;
			program_counter_ff <= `BIX_RST_PC;
			acc_ff             <= `BIX_RST_ACC;
			carry_ff           <= 1'b0;
			zero_ff            <= 1'b0;
			latch_ff           <= `BIX_RST_LATCH;
		end
		else
		begin
			state_ff       <= nxt_state;
			issue_ready_ff <= (nxt_state == S_IDLE);
			if (accept)
			begin
				op_ff <= issue_op;
				k_ff  <= issue_k;
				f_ff  <= issue_f;
				d_ff  <= issue_d;
			end
			if (accept && issue_op == `BIX_OP_OR_LITERAL)
			begin
				acc_ff             <= acc_ff | issue_k[`BIX_DATA_W-1:0];
				zero_ff            <= ((acc_ff | issue_k[`BIX_DATA_W-1:0]) == 8'h00);
				program_counter_ff <= program_counter_ff + 15'h0001;
			end
			if (state_ff == S_JUMP2)
				program_counter_ff <= {latch_ff[`BIX_LATCH_HI:`BIX_LATCH_LO], k_ff};
			if (state_ff == S_EXEC)
			begin
				if (!d_ff)
					acc_ff <= result;
				// The skipped instruction is never fetched; the counter steps over it here.
				if (op_ff == `BIX_OP_INCREMENT_SKIP && res_zero)
					program_counter_ff <= program_counter_ff + 15'h0002;
				else
					program_counter_ff <= program_counter_ff + 15'h0001;
				if (op_ff != `BIX_OP_INCREMENT_SKIP)
					zero_ff <= res_zero;
				if (op_ff == `BIX_OP_SHIFT_LEFT_FILE)
					carry_ff <= res_carry;
			end
			if (apb_req && pwrite && !apb_file)
			begin
				if (paddr == `BIX_OFS_ACC)
					acc_ff <= pwdata[`BIX_DATA_W-1:0];
				if (paddr == `BIX_OFS_STATUS)
				begin
					carry_ff <= pwdata[`BIX_ST_CARRY];
					zero_ff  <= pwdata[`BIX_ST_ZERO];
				end
				if (paddr == `BIX_OFS_LATCH)
					latch_ff <= pwdata[`BIX_LATCH_W-1:0];
			end
		end
	end

	// APB answers one cycle after the granted access edge, two for a file memory read.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff      <= 32'h00000000;
			pready_ff      <= 1'b0;
			pslverr_ff     <= 1'b0;
			apb_rd_pend_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			if (apb_rd_pend_ff)
			begin
				apb_rd_pend_ff <= 1'b0;
				pready_ff      <= 1'b1;
				prdata_ff      <= {24'h000000, mem_rdata};
			end
			else if (apb_req && !apb_file && !reg_hit(paddr))
			begin
				pready_ff  <= 1'b1;
				pslverr_ff <= 1'b1;
				prdata_ff  <= 32'h00000000;
			end
			else if (apb_req && apb_file && !pwrite)
				apb_rd_pend_ff <= 1'b1;
			else if (apb_req)
			begin
				pready_ff <= 1'b1;
				prdata_ff <= 32'h00000000;
				if (!pwrite)
				begin
					case (paddr)
						`BIX_OFS_ACC:
							prdata_ff <= {24'h000000, acc_ff};
						`BIX_OFS_STATUS:
							prdata_ff <= {30'h00000000, zero_ff, carry_ff};
						`BIX_OFS_LATCH:
							prdata_ff <= {25'h0000000, latch_ff};
						`BIX_OFS_PC:
							prdata_ff <= {17'h00000, program_counter_ff};
						default:
							prdata_ff <= 32'h00000000;
					endcase
				end
			end
		end
	end
endmodule

// *** bix_fetch_model.sv ***
// Instruction fetch stand-in that offers one instruction at a time.
// Assumes the execution block takes an offer at an edge with its ready high.
`timescale 1ns/1ps
`include "bix_consts.vh"
module bix_fetch_model (
	input  wire logic                     pclk,
	input  wire logic                     issue_ready_ff,
	output logic                          issue_valid,
	output logic [`BIX_OP_W-1:0]          issue_op,
	output logic [`BIX_JUMP_K_W-1:0]      issue_k,
	output logic [`BIX_FILE_AW-1:0]       issue_f,
	output logic                          issue_d
);
	initial
	begin
		issue_valid = 1'b0;
		issue_op = 3'h7;
		issue_k = 11'h0;
		issue_f = 7'h0;
		issue_d = 1'b0;
	end
	// Waits without a limit of its own; the bench watchdog ends a hang.
	task automatic wait_ready;
		do
		begin
			@(posedge pclk);
		end
		while (issue_ready_ff !== 1'b1);
	endtask
	// Fields are inverted once the offer is taken, so a stale operand never looks valid.
	task automatic issue(input logic [2:0] op, input logic [10:0] k, input logic [6:0] f, input logic d);
		@(posedge pclk);
		issue_valid <= 1'b1;
		issue_op <= op;
		issue_k <= k;
		issue_f <= f;
		issue_d <= d;
		wait_ready();
		issue_valid <= 1'b0;
		issue_op <= ~op;
		issue_k <= ~k;
		issue_f <= ~f;
		issue_d <= ~d;
		wait_ready();
	endtask
endmodule

// *** bix_exec_properties.sv ***
// Timing and result checks on the issue side of the execution block.
// Assumes it is bound to bix_exec and sees only that module's ports.
`timescale 1ns/1ps
`include "bix_consts.vh"
module bix_exec_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        issue_valid,
	input wire logic [2:0]  issue_op,
	input wire logic [10:0] issue_k,
	input wire logic        issue_d,
	input wire logic        issue_ready_ff,
	input wire logic [14:0] program_counter_ff,
	input wire logic [7:0]  acc_ff,
	input wire logic        carry_ff,
	input wire logic        zero_ff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       tk = issue_valid && issue_ready_ff;
	wire [7:0] k8 = issue_k[7:0];
	jump_load_a: assert property (tk && issue_op == `BIX_OP_JUMP_ABSOLUTE |=> !issue_ready_ff ##1
		issue_ready_ff && program_counter_ff[10:0] == $past(issue_k, 2)) else $error("jump target wrong");
	jump_flags_a: assert property (tk && issue_op == `BIX_OP_JUMP_ABSOLUTE |-> ##2
		carry_ff == $past(carry_ff, 2) && zero_ff == $past(zero_ff, 2)) else $error("jump changed a flag");
	skip_flags_a: assert property (tk && issue_op == `BIX_OP_INCREMENT_SKIP |-> ##3
		carry_ff == $past(carry_ff, 3) && zero_ff == $past(zero_ff, 3)) else $error("skip changed a flag");
	skip_pc_a: assert property (tk && issue_op == `BIX_OP_INCREMENT_SKIP && !issue_d |-> ##3
		program_counter_ff == $past(program_counter_ff, 3) + ((acc_ff == 8'h00) ? 15'h0002 : 15'h0001))
		else $error("skip advance wrong");
	skip_nop_a: assert property (tk && issue_op == `BIX_OP_INCREMENT_SKIP && !issue_d |=> !issue_ready_ff[*2]
		##1 (issue_ready_ff == (acc_ff != 8'h00))) else $error("skip busy time wrong");
	or_lit_a: assert property (tk && issue_op == `BIX_OP_OR_LITERAL |=> issue_ready_ff
		&& acc_ff == ($past(acc_ff) | $past(k8)) && zero_ff == (acc_ff == 8'h00)) else $error("or literal wrong");
	or_file_a: assert property (tk && issue_op == `BIX_OP_OR_FILE && !issue_d |-> ##3
		(acc_ff & $past(acc_ff, 3)) == $past(acc_ff, 3) && zero_ff == (acc_ff == 8'h00)) else $error("or file wrong");
	inc_file_a: assert property (tk && issue_op == `BIX_OP_INCREMENT_FILE && !issue_d |-> ##3
		zero_ff == (acc_ff == 8'h00) && program_counter_ff == $past(program_counter_ff, 3) + 15'h0001)
		else $error("increment wrong");
	shift_acc_a: assert property (tk && issue_op == `BIX_OP_SHIFT_LEFT_FILE && !issue_d |-> ##3
		!acc_ff[0] && zero_ff == (acc_ff == 8'h00)) else $error("shift low bit or zero wrong");
	shift_file_a: assert property (tk && issue_op == `BIX_OP_SHIFT_LEFT_FILE && issue_d |-> ##3
		acc_ff == $past(acc_ff, 3)) else $error("shift to file touched accumulator");
endmodule
bind bix_exec bix_exec_properties u_props (.pclk(pclk), .presetn(presetn), .issue_valid(issue_valid),
	.issue_op(issue_op), .issue_k(issue_k), .issue_d(issue_d), .issue_ready_ff(issue_ready_ff),
	.program_counter_ff(program_counter_ff), .acc_ff(acc_ff), .carry_ff(carry_ff), .zero_ff(zero_ff));

// *** mcu_branch_inc_or_shift_exec_test.sv ***
// Self-checking bench: APB register access plus instruction sequences.
// Assumes the fetch model issues instructions and file word f sits at 0x200 + 4*f.
`timescale 1ns/1ps
`include "bix_consts.vh"
module mcu_branch_inc_or_shift_exec_test;
	logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, err;
	logic        issue_valid, issue_d, issue_ready_ff, carry_ff, zero_ff;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_ff, rd;
	logic [2:0]  issue_op;
	logic [10:0] issue_k;
	logic [6:0]  issue_f;
	logic [14:0] program_counter_ff;
	logic [7:0]  acc_ff;
	int          error_cnt, checks;
	bix_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.issue_valid(issue_valid), .issue_op(issue_op), .issue_k(issue_k), .issue_f(issue_f), .issue_d(issue_d),
		.issue_ready_ff(issue_ready_ff), .program_counter_ff(program_counter_ff), .acc_ff(acc_ff),
		.carry_ff(carry_ff), .zero_ff(zero_ff));
	bix_fetch_model u_fetch (.pclk(pclk), .issue_ready_ff(issue_ready_ff), .issue_valid(issue_valid),
		.issue_op(issue_op), .issue_k(issue_k), .issue_f(issue_f), .issue_d(issue_d));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready_ff !== 1'b1);
		rd = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic flags(input string nm, input logic [1:0] exp);
		chk(nm, 32'({carry_ff, zero_ff}), 32'(exp));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// About 100 cycles are needed; the limit of 2000 cycles ends a hang in any of the unbounded waits.
	initial
	begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped error", 32'(err), 32'h1);
		$display("test map done");
		apb(1'b1, `BIX_OFS_STATUS, 32'h3);
		apb(1'b1, `BIX_OFS_LATCH, 32'h5A);
		u_fetch.issue(`BIX_OP_JUMP_ABSOLUTE, 11'h7FF, 7'h00, 1'b0);
		chk("jump pc", 32'(program_counter_ff), 32'h5FFF);
		flags("jump flags", 2'h3);
		apb(1'b0, `BIX_OFS_PC, 32'h0);
		chk("pc read", rd, 32'h5FFF);
		$display("test jump done");
		apb(1'b1, 12'h214, 32'hFF);
		u_fetch.issue(`BIX_OP_INCREMENT_SKIP, 11'h000, 7'h05, 1'b1);
		chk("skip zero pc", 32'(program_counter_ff), 32'h6001);
		flags("skip flags", 2'h3);
		apb(1'b0, 12'h214, 32'h0);
		chk("skip file", rd, 32'h0);
		u_fetch.issue(`BIX_OP_INCREMENT_SKIP, 11'h000, 7'h05, 1'b0);
		chk("skip acc", 32'(acc_ff), 32'h1);
		chk("skip pc", 32'(program_counter_ff), 32'h6002);
		$display("test skip done");
		u_fetch.issue(`BIX_OP_INCREMENT_FILE, 11'h000, 7'h05, 1'b1);
		apb(1'b0, 12'h214, 32'h0);
		chk("inc file", rd, 32'h1);
		u_fetch.issue(`BIX_OP_INCREMENT_FILE, 11'h000, 7'h05, 1'b0);
		chk("inc acc", 32'(acc_ff), 32'h2);
		flags("inc flags", 2'h2);
		$display("test increment done");
		apb(1'b1, 12'h218, 32'hC1);
		u_fetch.issue(`BIX_OP_SHIFT_LEFT_FILE, 11'h000, 7'h06, 1'b1);
		apb(1'b0, 12'h218, 32'h0);
		chk("shift file", rd, 32'h82);
		flags("shift flags", 2'h2);
		apb(1'b1, 12'h21C, 32'h80);
		u_fetch.issue(`BIX_OP_SHIFT_LEFT_FILE, 11'h000, 7'h07, 1'b0);
		chk("shift acc", 32'(acc_ff), 32'h0);
		flags("shift zero flags", 2'h3);
		$display("test shift done");
		u_fetch.issue(`BIX_OP_OR_LITERAL, 11'h75A, 7'h00, 1'b0);
		chk("or literal", 32'(acc_ff), 32'h5A);
		flags("or literal flags", 2'h2);
		u_fetch.issue(`BIX_OP_OR_FILE, 11'h000, 7'h06, 1'b1);
		apb(1'b0, 12'h218, 32'h0);
		chk("or file", rd, 32'hDA);
		u_fetch.issue(`BIX_OP_OR_FILE, 11'h000, 7'h06, 1'b0);
		chk("or acc", 32'(acc_ff), 32'hDA);
		apb(1'b1, `BIX_OFS_ACC, 32'h0);
		u_fetch.issue(`BIX_OP_OR_LITERAL, 11'h700, 7'h00, 1'b0);
		flags("or zero flags", 2'h3);
		$display("test or done");
		tally_and_finish();
	end
endmodule
